/* rtl/hcs_map.svh */
`ifndef HCS_MAP_SVH
`define HCS_MAP_SVH
`define HCS_READ_CODE      8'h02
`define HCS_WRITE_CODE     8'h82
`define HCS_IDX            8'h02
`define HCS_ADDR           32'h0000_0008
`define HCS_CMD_PORT_ADDR  32'h0000_0000
`define HCS_TALLY_LSB      16
`define HCS_TALLY_MSB      17
`define HCS_RESET_VALUE    32'h0000_0000
`define HCS_SET_MASK       32'hfffc_ffff
`endif

/* rtl/hcs_pkg.sv */
package hcs_pkg;
  typedef logic [1:0]  tally_t;
  typedef logic [31:0] word_t;
  typedef enum logic [1:0] {HTRANS_IDLE, HTRANS_BUSY, HTRANS_NONSEQ, HTRANS_SEQ} htrans_e;
endpackage : hcs_pkg

/* rtl/overrun_tally.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hcs_map.svh"
module overrun_tally
  import hcs_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   frame_end,
  input  wire logic   list_busy,
  output logic        overrun,
  output tally_t      tally
);
  logic   overrun_reg;
  logic   overrun_next;
  tally_t tally_reg;
  tally_t tally_next;

  always_comb begin
    overrun_next = frame_end & list_busy;
    tally_next   = tally_reg;
    if (overrun_next) begin
      tally_next = tally_reg + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      overrun_reg <= 1'b0;
      tally_reg   <= 2'h0;
    end else begin
      overrun_reg <= overrun_next;
      tally_reg   <= tally_next;
    end
  end

  assign overrun = overrun_reg;
  assign tally   = tally_reg;
endmodule : overrun_tally
`default_nettype wire

/* rtl/host_command_status.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hcs_map.svh"
module host_command_status
  import hcs_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // frame engine
  input  wire logic        FRAME_END,
  input  wire logic        PERIODIC_BUSY,
  // command bits and overrun flag
  output logic      [31:0] COMMAND_BITS,
  output logic             PERIODIC_OVERRUN_EVENT
);
  // command port: write 82h or 02h into it; offset 8 (index 2) reads status under any code, but takes writes only while the code is 82h
  logic        wr_pend_reg, wr_pend_next;
  logic [31:0] cmd_reg, cmd_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0]  code_reg, code_next;
  logic        addr_cmd_reg, addr_cmd_next;
  logic        ev_reg, ev_next;
  logic        overrun;
  tally_t      tally;
  logic        take;
  logic [31:0] status_word;

  overrun_tally u_tally (
    .clk       (CORE_CLK),
    .rst_n     (RST_N),
    .frame_end (FRAME_END),
    .list_busy (PERIODIC_BUSY),
    .overrun   (overrun),
    .tally     (tally)
  );

  assign take = HSEL & HREADY & (HTRANS == 2'(HTRANS_NONSEQ));

  always_comb begin
    status_word = cmd_reg & `HCS_SET_MASK;
    status_word[`HCS_TALLY_MSB:`HCS_TALLY_LSB] = tally;
  end

  always_comb begin
    wr_pend_next  = 1'b0;
    addr_cmd_next = addr_cmd_reg;
    cmd_next      = cmd_reg;
    code_next     = code_reg;
    rdata_next    = rdata_reg;
    ev_next       = overrun;
    if (wr_pend_reg) begin
      if (addr_cmd_reg) begin
        code_next = HWDATA[7:0];
      end else if (code_reg == `HCS_WRITE_CODE) begin
        cmd_next = (cmd_reg | HWDATA) & `HCS_SET_MASK;
      end
    end
    if (take) begin
      addr_cmd_next = (HADDR == `HCS_CMD_PORT_ADDR);
      wr_pend_next  = HWRITE;
      if (!HWRITE) begin
        // data register at offset 8 reads status whichever code was selected
        if (HADDR == `HCS_CMD_PORT_ADDR) begin
          rdata_next = {24'h0, code_reg};
        end else if (HADDR == `HCS_ADDR && code_reg == `HCS_READ_CODE) begin
          rdata_next = status_word;
        end else if (HADDR == `HCS_ADDR) begin
          rdata_next = status_word;
        end else begin
          rdata_next = 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      wr_pend_reg  <= 1'b0;
      addr_cmd_reg <= 1'b0;
      cmd_reg      <= `HCS_RESET_VALUE;
      code_reg     <= `HCS_WRITE_CODE;
      rdata_reg    <= 32'h0000_0000;
      ev_reg       <= 1'b0;
    end else begin
      wr_pend_reg  <= wr_pend_next;
      addr_cmd_reg <= addr_cmd_next;
      cmd_reg      <= cmd_next;
      code_reg     <= code_next;
      rdata_reg    <= rdata_next;
      ev_reg       <= ev_next;
    end
  end

  // zero wait state slave; hreadyout and hresp are flip-flops held constant
  logic hready_reg;
  logic hresp_reg;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      hready_reg <= 1'b1;
      hresp_reg  <= 1'b0;
    end else begin
      hready_reg <= 1'b1;
      hresp_reg  <= 1'b0;
    end
  end

  assign HRDATA                 = rdata_reg;
  assign HREADYOUT              = hready_reg;
  assign HRESP                  = hresp_reg;
  assign COMMAND_BITS           = cmd_reg;
  assign PERIODIC_OVERRUN_EVENT = ev_reg;
endmodule : host_command_status
`default_nettype wire

/* verification/hcs_chk_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module hcs_chk (
  input wire logic        CORE_CLK, RST_N, HSEL, HWRITE, HREADY, HREADYOUT, HRESP,
  input wire logic        FRAME_END, PERIODIC_BUSY, PERIODIC_OVERRUN_EVENT,
  input wire logic [1:0]  HTRANS,
  input wire logic [31:0] HADDR, HWDATA, COMMAND_BITS
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_ovr; FRAME_END && PERIODIC_BUSY; endsequence
  sequence s_wa; HSEL && HREADY && HTRANS == 2'h2 && HWRITE && HADDR == 32'h8; endsequence
  property p_ovr; s_ovr |-> ##[1:2] PERIODIC_OVERRUN_EVENT; endproperty
  property p_cause; PERIODIC_OVERRUN_EVENT |-> $past(FRAME_END && PERIODIC_BUSY)
    || $past(FRAME_END && PERIODIC_BUSY, 2); endproperty
  property p_keep; (COMMAND_BITS & $past(COMMAND_BITS)) == $past(COMMAND_BITS); endproperty
  property p_set; s_wa |=> ##1 (COMMAND_BITS & $past(HWDATA)) == ($past(HWDATA) & 32'hfffc_ffff);
  endproperty
  property p_fld; COMMAND_BITS[17:16] == 2'h0; endproperty
  property p_ok; HREADYOUT && !HRESP; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");
  a_cause: assert property (p_cause) else $error("overrun flag without cause");
  a_keep: assert property (p_keep) else $error("command bit cleared");
  a_set: assert property (p_set) else $error("written one not set");
  a_fld: assert property (p_fld) else $error("tally field in command bits");
  a_ok: assert property (p_ok) else $error("bus answer not okay");
endmodule : hcs_chk
bind host_command_status hcs_chk u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .HSEL(HSEL),
  .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .FRAME_END(FRAME_END), .PERIODIC_BUSY(PERIODIC_BUSY), .HTRANS(HTRANS), .HADDR(HADDR),
  .PERIODIC_OVERRUN_EVENT(PERIODIC_OVERRUN_EVENT), .HWDATA(HWDATA), .COMMAND_BITS(COMMAND_BITS));
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hcs_pkg::*;
  logic CORE_CLK = 0, RST_N = 0, HSEL = 0, HWRITE = 0, FRAME_END = 0, PERIODIC_BUSY = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, exp_cmd = 0, rnd = 32'h4542, q[$];
  logic [1:0]  HTRANS = 0, tl = 0;
  logic [2:0]  HSIZE = 3'h2;
  logic        rd_dp = 0;
  wire logic [31:0] HRDATA, COMMAND_BITS;
  wire logic        HREADYOUT, HRESP, PERIODIC_OVERRUN_EVENT;
  int err_count = 0, checks = 0, ev_cnt = 0;
  `define CHK(n, e, v) begin checks++; if ((v) !== (e)) begin err_count++; \
    $display("Error %s expected %h seen %h", n, e, v); end end
  always #20 CORE_CLK = ~CORE_CLK;
  host_command_status u_dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .FRAME_END(FRAME_END),
    .PERIODIC_BUSY(PERIODIC_BUSY), .COMMAND_BITS(COMMAND_BITS),
    .PERIODIC_OVERRUN_EVENT(PERIODIC_OVERRUN_EVENT));
  function automatic logic [31:0] nx(input logic [31:0] s);
    s ^= s << 13; s ^= s >> 17; s ^= s << 5; return s;
  endfunction : nx
  task automatic xfer(input logic w, input logic [31:0] a, d, e);
    HSEL <= 1; HTRANS <= HTRANS_NONSEQ; HWRITE <= w; HADDR <= a;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= HTRANS_IDLE; HWDATA <= d; rd_dp <= !w;
    if (!w) q.push_back(e);
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    rd_dp <= 0;
  endtask : xfer
  // read data is taken at the edge that closes the data phase
  always @(posedge CORE_CLK) if (rd_dp) `CHK("HRDATA", q.pop_front(), HRDATA)
  always @(posedge CORE_CLK) if (PERIODIC_OVERRUN_EVENT === 1'b1) ev_cnt++;
  task automatic ov(input logic b);
    FRAME_END <= 1; PERIODIC_BUSY <= b;
    @(posedge CORE_CLK);
    FRAME_END <= 0; tl += b;
    repeat (3) @(posedge CORE_CLK);
  endtask : ov
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    #200us; err_count++; report_and_stop;
  end
  initial begin
    repeat (3) @(posedge CORE_CLK);
    RST_N <= 1;
    xfer(0, 32'h8, 0, 0);
    for (int i = 0; i < 4; i++) begin
      rnd = nx(rnd); exp_cmd |= rnd & 32'hfffc_ffff;
      xfer(1, 32'h8, rnd, 0);
      xfer(0, 32'h8, 0, exp_cmd);
    end
    $display("set-only writes done");
    for (int i = 0; i < 6; i++) begin
      ov(i != 2);
      xfer(0, 32'h8, 0, exp_cmd | {14'h0, tl, 16'h0});
    end
    xfer(0, 32'h4, 0, 0);
    `CHK("COMMAND_BITS", exp_cmd, COMMAND_BITS)
    `CHK("overrun_events", 5, ev_cnt)
    $display("overrun tally done");
    report_and_stop;
  end
endmodule : tb
`default_nettype wire
